// File: core/cslb_map.vh
`ifndef CSLB_MAP_VH
`define CSLB_MAP_VH

// How it works
// [RL1] post-increment store: write, then pointer plus one
// [RL2] pre-decrement store: pointer minus one, then write
// [RL3] offset store: pointer plus displacement, pointer kept
// [RL4] direct store: address from instruction word
// [RL5] program read into register, optional Z increment
// [RL6] push and pop through stack, two clocks
// [RL7] io bit set/clear, two clocks, flags kept
// [RL8] rotate left through carry, updates Z,C,N,V
// [RL9] rotate right through carry, updates Z,C,N,V
// [RL10] register bit copied into T flag
// [RL11] T flag copied into register bit
// [RL12] flag set/clear instructions touch one flag
// [RL13] overflow flag set and clear
// [RL14] sleep accepted in one clock
// [RL15] watchdog restart in one clock
// [RL16] break only acts for on-chip debug
// [RL17] updated pointer written back within instruction

// ------------------------------------------------------------
// bus offsets
// ------------------------------------------------------------
`define CSLB_OFF_INSTR 8'h00
`define CSLB_OFF_STATUS 8'h04
`define CSLB_OFF_FLAGS 8'h08
`define CSLB_OFF_SP 8'h0C
`define CSLB_OFF_CTRL 8'h10
`define CSLB_RF_SEL 7
`define CSLB_RF_IDX 6:2

// ------------------------------------------------------------
// status and control bits
// ------------------------------------------------------------
`define CSLB_STAT_BUSY 0
`define CSLB_STAT_HALT 1
`define CSLB_CT_DBG 0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CSLB_RST_FLAGS 8'h00
`define CSLB_RST_SP 16'h01FF

// ------------------------------------------------------------
// instruction word fields
// ------------------------------------------------------------
`define CSLB_F_OPC 31:27
`define CSLB_F_REG 26:22
`define CSLB_F_BIT 21:19
`define CSLB_F_PTR 18
`define CSLB_F_MODE 17:16
`define CSLB_F_ADDR 15:0
`define CSLB_F_DISP 5:0
`define CSLB_F_IO 5:0

`define CSLB_MODE_POST 2'h1
`define CSLB_MODE_PRE 2'h2

// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define CSLB_OP_WIND 5'h01
`define CSLB_OP_WOFS 5'h02
`define CSLB_OP_WDIR 5'h03
`define CSLB_OP_PMR0 5'h04
`define CSLB_OP_PMRD 5'h05
`define CSLB_OP_PMRI 5'h06
`define CSLB_OP_PUSH 5'h07
`define CSLB_OP_POP 5'h08
`define CSLB_OP_IOSET 5'h09
`define CSLB_OP_IOCLR 5'h0A
`define CSLB_OP_LROT 5'h0B
`define CSLB_OP_RROT 5'h0C
`define CSLB_OP_TGET 5'h0D
`define CSLB_OP_TPUT 5'h0E
`define CSLB_OP_FSET 5'h0F
`define CSLB_OP_FCLR 5'h10
`define CSLB_OP_SLEEP 5'h11
`define CSLB_OP_WDOG 5'h12
`define CSLB_OP_BREAK 5'h13

// ------------------------------------------------------------
// status flag positions
// ------------------------------------------------------------
`define CSLB_FL_C 0
`define CSLB_FL_Z 1
`define CSLB_FL_N 2
`define CSLB_FL_V 3
`define CSLB_FL_S 4
`define CSLB_FL_H 5
`define CSLB_FL_T 6
`define CSLB_FL_I 7

// ------------------------------------------------------------
// pointer pairs and clock counts
// ------------------------------------------------------------
`define CSLB_Y_LO 5'h1C
`define CSLB_Z_LO 5'h1E
`define CSLB_Z_HI 5'h1F
`define CSLB_CLK_ONE 2'h1
`define CSLB_CLK_MEM 2'h2
`define CSLB_CLK_PM 2'h3

`endif

// File: core/cslb_rotate.v
`timescale 1ns/1ps
`include "cslb_map.vh"

module cslb_rotate (
  input wire rotRight,
  input wire [7:0] operand,
  input wire [7:0] flagsIn,
  output reg [7:0] result,
  output reg [7:0] flagsOut
);

  always @* begin
    flagsOut = flagsIn;
    if (rotRight) begin
      result = {flagsIn[`CSLB_FL_C], operand[7:1]}; // [RL9]
      flagsOut[`CSLB_FL_C] = operand[0]; // [RL9]
    end else begin
      result = {operand[6:0], flagsIn[`CSLB_FL_C]}; // [RL8]
      flagsOut[`CSLB_FL_C] = operand[7]; // [RL8]
    end
    // only Z, C, N, V move; H, S, T, I pass through
    flagsOut[`CSLB_FL_Z] = (result == 8'h00);
    flagsOut[`CSLB_FL_N] = result[7];
    flagsOut[`CSLB_FL_V] = result[7] ^ flagsOut[`CSLB_FL_C];
  end

endmodule // cslb_rotate

// File: core/cslb_core.v
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "cslb_map.vh"

module cslb_core (
  input wire clk,
  input wire nrst,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg [15:0] dmAddr,
  output reg [7:0] dmWdata,
  output reg dmWe,
  output reg dmRe,
  input wire [7:0] dmRdata,
  output reg [15:0] pmAddr,
  output reg pmRe,
  input wire [7:0] pmRdata,
  output reg [5:0] ioAddr,
  output reg [7:0] ioWdata,
  output reg ioWe,
  output reg ioRe,
  input wire [7:0] ioRdata,
  output reg sleepReq,
  output reg wdtRestart,
  output reg breakHit
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  localparam PEND_NONE = 2'h0;
  localparam PEND_POP = 2'h1;
  localparam PEND_PM = 2'h2;
  localparam PEND_IO = 2'h3;

  reg [7:0] regs [0:31];
  reg [31:0] instr;
  reg [1:0] busyCnt;
  reg [1:0] pendKind;
  reg [4:0] pendReg;
  reg [7:0] flags;
  reg [15:0] sp;
  reg halted;
  reg dbgEn;
  reg [31:0] rdData;
  integer i;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire busReq = cyc_i & stb_i & ~ack_o;
  wire busWr = busReq & we_i;
  wire idle = (busyCnt == 2'h0);
  wire rfHit = adr_i[`CSLB_RF_SEL];
  wire [4:0] rfIdx = adr_i[`CSLB_RF_IDX];
  // instruction words need all four lanes so no half word executes
  wire issueNow = busWr & (adr_i == `CSLB_OFF_INSTR) & idle & ~halted
    & (sel_i == 4'hF);
  // registers, flags and SP are frozen while an instruction is in flight; control and halt clear stay writable
  wire stateWr = busWr & idle;
  wire haltClr = busWr & (adr_i == `CSLB_OFF_STATUS) & sel_i[0]
    & dat_i[`CSLB_STAT_HALT];

  // ------------------------------------------------------------
  // operand decode of the word being issued; io mask and set/clear select from the latched instr
  // ------------------------------------------------------------
  wire [4:0] opc = dat_i[`CSLB_F_OPC];
  wire [4:0] rSel = dat_i[`CSLB_F_REG];
  wire [2:0] bSel = dat_i[`CSLB_F_BIT];
  wire [1:0] mode = dat_i[`CSLB_F_MODE];
  wire [4:0] ptrLo = dat_i[`CSLB_F_PTR] ? `CSLB_Z_LO : `CSLB_Y_LO;
  wire [4:0] ptrHi = ptrLo | 5'h01;
  wire [15:0] ptrVal = {regs[ptrHi], regs[ptrLo]};
  wire [15:0] ptrInc = ptrVal + 16'h0001;
  wire [15:0] ptrDec = ptrVal - 16'h0001;
  wire [15:0] dispAddr = ptrVal + {10'h000, dat_i[`CSLB_F_DISP]};
  wire [15:0] zVal = {regs[`CSLB_Z_HI], regs[`CSLB_Z_LO]};
  wire [15:0] zInc = zVal + 16'h0001;
  wire [15:0] spInc = sp + 16'h0001;
  wire [7:0] srcVal = regs[rSel];
  wire [7:0] bitMask = 8'h01 << bSel;
  wire [7:0] tCopyVal = flags[`CSLB_FL_T] ? (srcVal | bitMask)
    : (srcVal & ~bitMask);
  wire [7:0] ioMask = 8'h01 << instr[`CSLB_F_BIT];
  wire ioSetOp = (instr[`CSLB_F_OPC] == `CSLB_OP_IOSET);
  wire [7:0] rotRes;
  wire [7:0] rotFlags;

  cslb_rotate u_rot (
    .rotRight(opc == `CSLB_OP_RROT),
    .operand(srcVal),
    .flagsIn(flags),
    .result(rotRes),
    .flagsOut(rotFlags)
  );

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  always @* begin
    rdData = 32'h0000_0000;
    if (rfHit) begin
      rdData = {24'h00_0000, regs[rfIdx]};
    end else begin
      case (adr_i)
        `CSLB_OFF_INSTR: rdData = instr;
        `CSLB_OFF_STATUS: rdData = {30'h0000_0000, halted, ~idle};
        `CSLB_OFF_FLAGS: rdData = {24'h00_0000, flags};
        `CSLB_OFF_SP: rdData = {16'h0000, sp};
        `CSLB_OFF_CTRL: rdData = {31'h0000_0000, dbgEn};
        default: rdData = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // bus slave, execution and register file
  // ------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dat_o <= 32'h0000_0000;
      ack_o <= 1'b0;
      dmAddr <= 16'h0000;
      dmWdata <= 8'h00;
      dmWe <= 1'b0;
      dmRe <= 1'b0;
      pmAddr <= 16'h0000;
      pmRe <= 1'b0;
      ioAddr <= 6'h00;
      ioWdata <= 8'h00;
      ioWe <= 1'b0;
      ioRe <= 1'b0;
      sleepReq <= 1'b0;
      wdtRestart <= 1'b0;
      breakHit <= 1'b0;
      instr <= 32'h0000_0000;
      busyCnt <= 2'h0;
      pendKind <= PEND_NONE;
      pendReg <= 5'h00;
      flags <= `CSLB_RST_FLAGS;
      sp <= `CSLB_RST_SP;
      halted <= 1'b0;
      dbgEn <= 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        regs[i] <= 8'h00;
      end
    end else begin
      ack_o <= busReq;
      dmWe <= 1'b0;
      dmRe <= 1'b0;
      pmRe <= 1'b0;
      ioRe <= 1'b0;
      ioWe <= 1'b0;
      sleepReq <= 1'b0;
      wdtRestart <= 1'b0;
      breakHit <= 1'b0;
      if (!idle) begin
        busyCnt <= busyCnt - 2'h1;
      end
      if (busReq && !we_i) begin
        dat_o <= rdData;
      end

      // plain software writes
      if (stateWr && rfHit && sel_i[0]) begin
        regs[rfIdx] <= dat_i[7:0];
      end
      if (stateWr && adr_i == `CSLB_OFF_FLAGS && sel_i[0]) begin
        flags <= dat_i[7:0];
      end
      if (stateWr && adr_i == `CSLB_OFF_SP) begin
        if (sel_i[0]) begin
          sp[7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          sp[15:8] <= dat_i[15:8];
        end
      end
      if (busWr && adr_i == `CSLB_OFF_CTRL && sel_i[0]) begin
        dbgEn <= dat_i[`CSLB_CT_DBG];
      end

      // data returning from memories: pop on its last busy cycle, program read one cycle before its last
      if (pendKind == PEND_POP && busyCnt == 2'h1) begin
        regs[pendReg] <= dmRdata; // [RL6]
        pendKind <= PEND_NONE;
      end
      if (pendKind == PEND_PM && busyCnt == 2'h2) begin
        regs[pendReg] <= pmRdata; // [RL5]
        pendKind <= PEND_NONE;
      end
      // io read is combinational, so modify and write back at once
      if (pendKind == PEND_IO && busyCnt == 2'h2) begin
        ioWdata <= ioSetOp ? (ioRdata | ioMask) : (ioRdata & ~ioMask); // [RL7]
        ioWe <= 1'b1; // [RL7]
        pendKind <= PEND_NONE;
      end

      // break sets halt; a halt clear in the same cycle loses
      if (haltClr) begin
        halted <= 1'b0;
      end

      if (issueNow) begin
        instr <= dat_i;
        busyCnt <= `CSLB_CLK_ONE;
        case (opc)
          `CSLB_OP_WIND: begin
            busyCnt <= `CSLB_CLK_MEM; // [RL1] [RL2]
            dmWdata <= srcVal;
            dmWe <= 1'b1;
            if (mode == `CSLB_MODE_PRE) begin
              dmAddr <= ptrDec; // [RL2]
              regs[ptrLo] <= ptrDec[7:0]; // [RL17]
              regs[ptrHi] <= ptrDec[15:8]; // [RL17]
            end else if (mode == `CSLB_MODE_POST) begin
              dmAddr <= ptrVal; // [RL1]
              regs[ptrLo] <= ptrInc[7:0]; // [RL17]
              regs[ptrHi] <= ptrInc[15:8]; // [RL17]
            end else begin
              dmAddr <= ptrVal;
            end
          end
          `CSLB_OP_WOFS: begin
            busyCnt <= `CSLB_CLK_MEM; // [RL3]
            dmAddr <= dispAddr; // [RL3]
            dmWdata <= srcVal;
            dmWe <= 1'b1;
          end
          `CSLB_OP_WDIR: begin
            busyCnt <= `CSLB_CLK_MEM; // [RL4]
            dmAddr <= dat_i[`CSLB_F_ADDR]; // [RL4]
            dmWdata <= srcVal;
            dmWe <= 1'b1;
          end
          `CSLB_OP_PMR0, `CSLB_OP_PMRD, `CSLB_OP_PMRI: begin
            busyCnt <= `CSLB_CLK_PM; // [RL5]
            pmAddr <= zVal;
            pmRe <= 1'b1;
            pendKind <= PEND_PM;
            pendReg <= (opc == `CSLB_OP_PMR0) ? 5'h00 : rSel; // [RL5]
            if (opc == `CSLB_OP_PMRI) begin
              regs[`CSLB_Z_LO] <= zInc[7:0]; // [RL17]
              regs[`CSLB_Z_HI] <= zInc[15:8]; // [RL17]
            end
          end
          `CSLB_OP_PUSH: begin
            busyCnt <= `CSLB_CLK_MEM; // [RL6]
            dmAddr <= sp;
            dmWdata <= srcVal;
            dmWe <= 1'b1;
            sp <= sp - 16'h0001;
          end
          `CSLB_OP_POP: begin
            busyCnt <= `CSLB_CLK_MEM; // [RL6]
            dmAddr <= spInc;
            dmRe <= 1'b1;
            sp <= spInc;
            pendKind <= PEND_POP;
            pendReg <= rSel;
          end
          `CSLB_OP_IOSET, `CSLB_OP_IOCLR: begin
            busyCnt <= `CSLB_CLK_MEM; // [RL7]
            ioAddr <= dat_i[`CSLB_F_IO];
            ioRe <= 1'b1;
            pendKind <= PEND_IO;
          end
          `CSLB_OP_LROT, `CSLB_OP_RROT: begin
            regs[rSel] <= rotRes; // [RL8] [RL9]
            flags <= rotFlags; // [RL8] [RL9]
          end
          `CSLB_OP_TGET: begin
            flags[`CSLB_FL_T] <= srcVal[bSel]; // [RL10]
          end
          `CSLB_OP_TPUT: begin
            regs[rSel] <= tCopyVal; // [RL11]
          end
          `CSLB_OP_FSET: begin
            flags[bSel] <= 1'b1; // [RL12] [RL13]
          end
          `CSLB_OP_FCLR: begin
            flags[bSel] <= 1'b0; // [RL12] [RL13]
          end
          `CSLB_OP_SLEEP: begin
            sleepReq <= 1'b1; // [RL14]
          end
          `CSLB_OP_WDOG: begin
            wdtRestart <= 1'b1; // [RL15]
          end
          `CSLB_OP_BREAK: begin
            // without debug enabled the opcode is a one-clock no-op
            if (dbgEn) begin
              breakHit <= 1'b1; // [RL16]
              halted <= 1'b1; // [RL16]
            end
          end
          default: begin
            busyCnt <= `CSLB_CLK_ONE;
          end
        endcase
      end
    end
  end

endmodule // cslb_core

// File: verif/cslb_checker.sv
`timescale 1ns/1ps
`include "cslb_map.vh"

module cslb_checker (
  input wire clk,
  input wire nrst,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire ack_o,
  input wire dmWe,
  input wire dmRe,
  input wire pmRe,
  input wire ioRe,
  input wire ioWe,
  input wire [5:0] ioAddr,
  input wire [7:0] ioWdata,
  input wire [7:0] ioRdata,
  input wire sleepReq,
  input wire wdtRestart,
  input wire breakHit
);
  wire issue = cyc_i & stb_i & ~ack_o & we_i & (adr_i[7:2] == 6'h00) & (&sel_i);
  wire [4:0] op = dat_i[31:27];
  reg [31:0] lastWord;
  wire [7:0] bitMask = 8'h01 << lastWord[21:19];
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) lastWord <= 32'h0000_0000;
    else if (issue) lastWord <= dat_i;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_store_cause: assert property (dmWe |-> $past(issue) && $past(op) inside
    {`CSLB_OP_WIND, `CSLB_OP_WOFS, `CSLB_OP_WDIR, `CSLB_OP_PUSH}) else $error("stray store");
  chk_pop_cause: assert property (dmRe |-> $past(issue) && $past(op) == `CSLB_OP_POP)
    else $error("stray data read");
  chk_pm_cause: assert property (pmRe |-> $past(issue) && $past(op) inside
    {`CSLB_OP_PMR0, `CSLB_OP_PMRD, `CSLB_OP_PMRI}) else $error("stray program read");
  chk_io_pair: assert property (ioRe |=> ioWe && $stable(ioAddr)) else $error("io write lost");
  chk_io_value: assert property (ioWe |-> ioWdata == (lastWord[31:27] == `CSLB_OP_IOSET ?
    ($past(ioRdata) | bitMask) : ($past(ioRdata) & ~bitMask))) else $error("io bit wrong");
  chk_sleep_cause: assert property (sleepReq |-> $past(issue) && $past(op) == `CSLB_OP_SLEEP)
    else $error("stray sleep");
  chk_wdt_cause: assert property (wdtRestart |-> $past(issue) && $past(op) == `CSLB_OP_WDOG)
    else $error("stray watchdog restart");
  chk_brk_cause: assert property (breakHit |-> $past(issue) && $past(op) == `CSLB_OP_BREAK)
    else $error("stray break");
  cov_store: cover property (dmWe);
  cov_pm: cover property (pmRe);
  cov_io: cover property (ioWe);
endmodule // cslb_checker

bind cslb_core cslb_checker chk_u (.clk, .nrst, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i,
  .ack_o, .dmWe, .dmRe, .pmRe, .ioRe, .ioWe, .ioAddr, .ioWdata, .ioRdata, .sleepReq,
  .wdtRestart, .breakHit);

// File: verif/cslb_mem_model.sv
`timescale 1ns/1ps

module cslb_mem_model (
  input wire clk,
  input wire [15:0] dmAddr,
  input wire [7:0] dmWdata,
  input wire dmWe,
  input wire dmRe,
  output logic [7:0] dmRdata,
  input wire [15:0] pmAddr,
  input wire pmRe,
  output logic [7:0] pmRdata,
  input wire [5:0] ioAddr,
  input wire [7:0] ioWdata,
  input wire ioWe,
  input wire ioRe,
  output logic [7:0] ioRdata
);
  logic [7:0] dm [0:65535];
  logic [7:0] io [0:63];
  initial begin
    dmRdata = 8'h00;
    pmRdata = 8'h00;
  end
  // data and program read buses toggle outside their valid cycle, and the io read bus shows inverted data, so stale data never passes
  always @(posedge clk) begin
    if (dmWe) dm[dmAddr] <= dmWdata;
    dmRdata <= dmRe ? dm[dmAddr] : ~dmRdata;
    pmRdata <= pmRe ? (pmAddr[7:0] ^ 8'h5A) : ~pmRdata;
    if (ioWe) io[ioAddr] <= ioWdata;
  end
  assign ioRdata = ioRe ? io[ioAddr] : ~io[ioAddr];
endmodule // cslb_mem_model

// File: verif/tb_cpu_store_load_bit_ops.sv
`timescale 1ns/1ps
`include "cslb_map.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end

module tb_cpu_store_load_bit_ops;
  typedef struct packed {logic [31:0] w; logic [7:0] ri, fi, ro, fo;} cslb_row_t;
  logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rd, brkWord;
  logic [3:0] sel = 4'h0;
  wire [31:0] rdat;
  wire [15:0] dmAddr, pmAddr;
  wire [7:0] dmWdata, dmRdata, pmRdata, ioWdata, ioRdata;
  wire [5:0] ioAddr;
  wire ack, dmWe, dmRe, pmRe, ioWe, ioRe, sleepReq, wdtRestart, breakHit;
  int miscompares = 0, samples_checked = 0;
  // four-state counters so an unknown pulse cannot hide as zero
  logic [7:0] nSleep = 8'h00, nWdt = 8'h00, nBrk = 8'h00;
  cslb_row_t rows [10];

  cslb_core dut_u (.clk(clk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack), .dmAddr(dmAddr), .dmWdata(dmWdata),
    .dmWe(dmWe), .dmRe(dmRe), .dmRdata(dmRdata), .pmAddr(pmAddr), .pmRe(pmRe),
    .pmRdata(pmRdata), .ioAddr(ioAddr), .ioWdata(ioWdata), .ioWe(ioWe), .ioRe(ioRe),
    .ioRdata(ioRdata), .sleepReq(sleepReq), .wdtRestart(wdtRestart), .breakHit(breakHit));
  cslb_mem_model mem_u (.clk(clk), .dmAddr(dmAddr), .dmWdata(dmWdata), .dmWe(dmWe),
    .dmRe(dmRe), .dmRdata(dmRdata), .pmAddr(pmAddr), .pmRe(pmRe), .pmRdata(pmRdata),
    .ioAddr(ioAddr), .ioWdata(ioWdata), .ioWe(ioWe), .ioRe(ioRe), .ioRdata(ioRdata));

  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    nSleep += sleepReq;
    nWdt += wdtRestart;
    nBrk += breakHit;
  end

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task complete_run;
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, s};
    n = 0;
    // ack is read before this edge's updates land, i.e. as sampled by the edge
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin miscompares++; complete_run(); end
    rd = rdat;
    {cyc, stb, we} <= 3'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task rdr(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
  endtask
  task putReg(input int n, input logic [7:0] v);
    wr(8'h80 + 8'(n * 4), {24'h00_0000, v});
  endtask
  task getReg(input int n);
    rdr(8'h80 + 8'(n * 4));
  endtask
  task run(input logic [31:0] w);
    int n;
    wr(8'h00, w);
    n = 0;
    do begin rdr(8'h04); n++; end while (rd[0] !== 1'b0 && n < 20);
    if (n >= 20) begin miscompares++; complete_run(); end
  endtask
  function automatic logic [31:0] mk(input logic [4:0] o, input logic [4:0] r,
    input logic [2:0] b, input logic p, input logic [1:0] m, input logic [15:0] a);
    return {o, r, b, p, m, a};
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    rows = '{'{mk(`CSLB_OP_LROT, 16, 0, 0, 0, 0), 8'h80, 8'h01, 8'h01, 8'h09},
      '{mk(`CSLB_OP_LROT, 16, 0, 0, 0, 0), 8'h00, 8'hF0, 8'h00, 8'hF2},
      '{mk(`CSLB_OP_RROT, 16, 0, 0, 0, 0), 8'h01, 8'h00, 8'h00, 8'h0B},
      '{mk(`CSLB_OP_RROT, 16, 0, 0, 0, 0), 8'h02, 8'h01, 8'h81, 8'h0C},
      '{mk(`CSLB_OP_TGET, 16, 3, 0, 0, 0), 8'h08, 8'h00, 8'h08, 8'h40},
      '{mk(`CSLB_OP_TGET, 16, 3, 0, 0, 0), 8'hF7, 8'hFF, 8'hF7, 8'hBF},
      '{mk(`CSLB_OP_TPUT, 16, 5, 0, 0, 0), 8'h00, 8'h40, 8'h20, 8'h40},
      '{mk(`CSLB_OP_TPUT, 16, 0, 0, 0, 0), 8'hFF, 8'hBF, 8'hFE, 8'hBF},
      '{mk(`CSLB_OP_SLEEP, 0, 0, 0, 0, 0), 8'h5A, 8'h5A, 8'h5A, 8'h5A},
      '{mk(`CSLB_OP_WDOG, 0, 0, 0, 0, 0), 8'h3C, 8'hA5, 8'h3C, 8'hA5}};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rdr(8'h08);
    `CHK(rd, 32'h0000_0000)
    rdr(8'h0C);
    `CHK(rd[15:0], 16'h01FF)
    rdr(8'h04);
    `CHK(rd, 32'h0000_0000)
    foreach (rows[i]) begin
      wr(8'h08, {24'h00_0000, rows[i].fi});
      putReg(16, rows[i].ri);
      run(rows[i].w);
      rdr(8'h08);
      `CHK(rd[7:0], rows[i].fo)
      getReg(16);
      `CHK(rd[7:0], rows[i].ro)
    end
    `CHK(nSleep, 8'h01)
    `CHK(nWdt, 8'h01)
    for (int i = 0; i < 8; i++) begin
      wr(8'h08, 32'h0000_0000);
      run(mk(`CSLB_OP_FSET, 0, 3'(i), 0, 0, 0));
      rdr(8'h08);
      `CHK(rd[7:0], 8'h01 << i)
      wr(8'h08, 32'h0000_00FF);
      run(mk(`CSLB_OP_FCLR, 0, 3'(i), 0, 0, 0));
      rdr(8'h08);
      `CHK(rd[7:0], ~(8'h01 << i))
    end
    wr(8'h08, 32'h0000_00A5);
    putReg(28, 8'h00);
    putReg(29, 8'h01);
    putReg(16, 8'h3C);
    putReg(17, 8'h77);
    run(mk(`CSLB_OP_WIND, 16, 0, 0, `CSLB_MODE_POST, 0));
    `CHK(mem_u.dm[16'h0100], 8'h3C)
    getReg(28);
    `CHK(rd[7:0], 8'h01)
    run(mk(`CSLB_OP_WIND, 17, 0, 0, `CSLB_MODE_PRE, 0));
    `CHK(mem_u.dm[16'h0100], 8'h77)
    getReg(28);
    `CHK(rd[7:0], 8'h00)
    // plain indirect form: store at the pointer, pointer left alone
    run(mk(`CSLB_OP_WIND, 16, 0, 0, 0, 0));
    `CHK(mem_u.dm[16'h0100], 8'h3C)
    getReg(28);
    `CHK(rd[7:0], 8'h00)
    putReg(30, 8'h00);
    putReg(31, 8'h00);
    run(mk(`CSLB_OP_WIND, 16, 0, 1, `CSLB_MODE_PRE, 0));
    `CHK(mem_u.dm[16'hFFFF], 8'h3C)
    getReg(31);
    `CHK(rd[7:0], 8'hFF)
    putReg(30, 8'h00);
    putReg(31, 8'h02);
    run(mk(`CSLB_OP_WOFS, 17, 0, 1, 0, 16'h003F));
    `CHK(mem_u.dm[16'h023F], 8'h77)
    getReg(30);
    `CHK(rd[7:0], 8'h00)
    run(mk(`CSLB_OP_WDIR, 16, 0, 0, 0, 16'h1234));
    `CHK(mem_u.dm[16'h1234], 8'h3C)
    putReg(30, 8'hFF);
    putReg(31, 8'h00);
    run(mk(`CSLB_OP_PMR0, 0, 0, 0, 0, 0));
    getReg(0);
    `CHK(rd[7:0], 8'hA5)
    run(mk(`CSLB_OP_PMRD, 20, 0, 0, 0, 0));
    getReg(20);
    `CHK(rd[7:0], 8'hA5)
    run(mk(`CSLB_OP_PMRI, 21, 0, 0, 0, 0));
    getReg(21);
    `CHK(rd[7:0], 8'hA5)
    getReg(31);
    `CHK(rd[7:0], 8'h01)
    run(mk(`CSLB_OP_PUSH, 16, 0, 0, 0, 0));
    `CHK(mem_u.dm[16'h01FF], 8'h3C)
    rdr(8'h0C);
    `CHK(rd[15:0], 16'h01FE)
    run(mk(`CSLB_OP_POP, 22, 0, 0, 0, 0));
    getReg(22);
    `CHK(rd[7:0], 8'h3C)
    mem_u.io[5] = 8'h81;
    run(mk(`CSLB_OP_IOSET, 0, 2, 0, 0, 16'h0005));
    `CHK(mem_u.io[5], 8'h85)
    run(mk(`CSLB_OP_IOCLR, 0, 7, 0, 0, 16'h0005));
    `CHK(mem_u.io[5], 8'h05)
    rdr(8'h08);
    `CHK(rd[7:0], 8'hA5)
    // an undecoded opcode is a one-clock no-op
    run(mk(5'h1F, 16, 0, 0, 0, 0));
    getReg(16);
    `CHK(rd[7:0], 8'h3C)
    brkWord = mk(`CSLB_OP_BREAK, 0, 0, 0, 0, 0);
    run(brkWord);
    rdr(8'h04);
    `CHK(rd[1], 1'b0)
    wr(8'h10, 32'h0000_0001);
    run(brkWord);
    `CHK(nBrk, 8'h01)
    rdr(8'h04);
    `CHK(rd[1:0], 2'h2)
    rdr(8'h08);
    `CHK(rd[7:0], 8'hA5)
    wr(8'h00, mk(`CSLB_OP_SLEEP, 0, 0, 0, 0, 0));
    rdr(8'h00);
    `CHK(rd, brkWord)
    wr(8'h04, 32'h0000_0002);
    rdr(8'h04);
    `CHK(rd[1], 1'b0)
    wb(1'b1, 8'h00, mk(`CSLB_OP_SLEEP, 0, 0, 0, 0, 0), 4'h7);
    rdr(8'h00);
    `CHK(rd, brkWord)
    `CHK(nSleep, 8'h01)
    wr(8'h20, 32'hFFFF_FFFF);
    rdr(8'h20);
    `CHK(rd, 32'h0000_0000)
    // mid-run reset must bring back the reset values of flags, SP, control, register 16 and status
    wr(8'h10, 32'h0000_0001);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdr(8'h08);
    `CHK(rd, 32'h0000_0000)
    rdr(8'h0C);
    `CHK(rd[15:0], 16'h01FF)
    rdr(8'h10);
    `CHK(rd, 32'h0000_0000)
    getReg(16);
    `CHK(rd, 32'h0000_0000)
    rdr(8'h04);
    `CHK(rd, 32'h0000_0000)
    complete_run();
  end
endmodule // tb_cpu_store_load_bit_ops
